/* irq_ctrl_cfg.svh */
// Constants for the two-level interrupt controller.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH

`define IRQ_NUM_SRC 15
`define IRQ_VEC_W 16
`define IRQ_ADDR_W 4
`define IRQ_DATA_W 16
`define IRQ_VEC_BASE 16'h0003
`define IRQ_VEC_STEP 16'h0008

// Register indices on the plain register port
`define IRQ_REG_ENABLE 4'h0
`define IRQ_REG_PRIO 4'h1
`define IRQ_REG_PEND 4'h2
`define IRQ_REG_CTRL 4'h3
`define IRQ_REG_STATUS 4'h4
`define IRQ_REG_PEND_SET 4'h5
`define IRQ_REG_PEND_CLR 4'h6

// Control register fields
`define IRQ_CTRL_GLOBAL_BIT 0

// Sources whose pending flag hardware clears on vectoring (orders 0..3)
`define IRQ_AUTO_CLEAR_MASK 15'h000f

// The call holds call_req four cycles after detection; call_start follows on the fifth
`define IRQ_CALL_CYCLES 3'h4
`define IRQ_CALL_LAST 3'h3

`endif

/* irq_ctrl_pkg.sv */
// Types shared by the interrupt controller modules.
// Assumes irq_ctrl_cfg.svh is on the include path.
`include "irq_ctrl_cfg.svh"

package irq_ctrl_pkg;
    typedef logic [`IRQ_NUM_SRC-1:0] src_vec_t;
    typedef logic [`IRQ_VEC_W-1:0] vec_addr_t;
    typedef logic [3:0] src_idx_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CALL,
        ST_SERVICE,
        ST_RETURN,
        ST_ONE_MORE
    } seq_state_t;
endpackage : irq_ctrl_pkg

/* irq_arbiter.sv */
// Priority arbiter: high level before low, lowest order index wins inside a level.
// Assumes requests already gated by enables; purely combinational.
`timescale 1ns/1ns
`include "irq_ctrl_cfg.svh"

module irq_arbiter (
    input wire logic [`IRQ_NUM_SRC-1:0] req,
    input wire logic [`IRQ_NUM_SRC-1:0] prio_high,
    output logic hit_high,
    output logic hit_low,
    output logic [3:0] idx_high,
    output logic [3:0] idx_low
);
    logic [`IRQ_NUM_SRC-1:0] req_high;
    logic [`IRQ_NUM_SRC-1:0] req_low;

    assign req_high = req & prio_high;
    assign req_low = req & ~prio_high;

    // RQ12 fixed source order
    always_comb begin
        hit_high = 1'b0;
        hit_low = 1'b0;
        idx_high = 4'h0;
        idx_low = 4'h0;
        for (int i = `IRQ_NUM_SRC - 1; i >= 0; i--) begin
            if (req_high[i]) begin
                hit_high = 1'b1;
                idx_high = 4'(i);
            end
            if (req_low[i]) begin
                hit_low = 1'b1;
                idx_low = 4'(i);
            end
        end
    end
endmodule : irq_arbiter

/* irq_ctrl.sv */
// Two-level interrupt controller top: pending flags, enables, arbitration,
// vector request to the instruction sequencer, return handling.
// Assumes the sequencer pulses instr_done per completed instruction and
// return_from_interrupt_instruction_done when a return-from-interrupt instruction completes.
//
// Overview of operation
// RQ1: Fifteen sources are accepted, each set to low or high priority.
// RQ2: A source event sets its pending flag whatever its enable.
// RQ3: An enabled pending source raises a request, taken once the current instruction completes.
// RQ4: On return-from-interrupt the core resumes where it was; the controller frees the level.
// RQ5: Pending flags of disabled sources are ignored when deciding requests.
// RQ6: Each source has its own enable bit.
// RQ7: Per-source enables count only while the global enable is one.
// RQ8: A zero global enable blocks every source.
// RQ9: Some sources have their flag cleared on vectoring; others need software clearing.
// RQ10: A flag still set after return re-enters after one further instruction.
// RQ11: High preempts low service, high is never preempted, low is the reset level.
// RQ12: Higher priority wins in a tie, then a fixed source order.
// RQ13: Requests are decoded every cycle; fastest response is five cycles.
// RQ14: One grant at a time is shown with its vector until the call begins.
`timescale 1ns/1ns
`include "irq_ctrl_cfg.svh"

module irq_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [`IRQ_NUM_SRC-1:0] src_event,
    input wire logic instr_done,
    input wire logic return_from_interrupt_instruction_done,
    input wire logic [`IRQ_ADDR_W-1:0] reg_addr,
    input wire logic [`IRQ_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [`IRQ_DATA_W-1:0] reg_rdata,
    output logic call_req,
    output logic [`IRQ_VEC_W-1:0] call_vector,
    output logic call_start,
    output logic [`IRQ_NUM_SRC-1:0] pending
);
    ////////////////////////////////////////////////////////////////////
    logic global_irq_enable;
    logic [`IRQ_NUM_SRC-1:0] irq_enable_register;
    logic [`IRQ_NUM_SRC-1:0] irq_priority_register;
    logic active_low_lvl;
    logic active_high_lvl;
    logic low_saved;
    irq_ctrl_pkg::seq_state_t state;
    logic [2:0] call_cnt;
    logic [3:0] grant_idx;
    logic grant_high;
    logic [`IRQ_NUM_SRC-1:0] eligible;
    logic hit_high;
    logic hit_low;
    logic [3:0] idx_high;
    logic [3:0] idx_low;
    logic can_high;
    logic can_low;
    logic decide;
    logic take;
    logic take_high;
    logic [3:0] take_idx;
    logic [`IRQ_NUM_SRC-1:0] sw_set;
    logic [`IRQ_NUM_SRC-1:0] sw_clr;
    logic [`IRQ_NUM_SRC-1:0] hw_clr;
    logic [`IRQ_NUM_SRC-1:0] next_pending;
    logic call_end;
    localparam logic [`IRQ_NUM_SRC-1:0] auto_clr_mask = `IRQ_AUTO_CLEAR_MASK;

    ////////////////////////////////////////////////////////////////////
    // RQ5 RQ6 RQ7 RQ8 enable gating
    assign eligible = pending & irq_enable_register & {`IRQ_NUM_SRC{global_irq_enable}};

    // RQ1 RQ12 arbitration
    irq_arbiter u_arb (
        .req(eligible),
        .prio_high(irq_priority_register),
        .hit_high(hit_high),
        .hit_low(hit_low),
        .idx_high(idx_high),
        .idx_low(idx_low)
    );

    // RQ11 preemption limits
    assign can_high = !active_high_lvl;
    assign can_low = !active_high_lvl && !active_low_lvl;
    // RQ13 decoded each cycle, taken at instruction boundary
    assign decide = (state == irq_ctrl_pkg::ST_IDLE || state == irq_ctrl_pkg::ST_SERVICE)
        && instr_done;
    assign take_high = hit_high && can_high;
    assign take = decide && (take_high || (hit_low && can_low));
    assign take_idx = take_high ? idx_high : idx_low;
    // RQ9 RQ13 last cycle of the call
    assign call_end = state == irq_ctrl_pkg::ST_CALL && call_cnt == `IRQ_CALL_LAST;

    ////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            global_irq_enable <= 1'b0;
            irq_enable_register <= '0;
            irq_priority_register <= '0;
        end else if (reg_write) begin
            case (reg_addr)
                `IRQ_REG_ENABLE: irq_enable_register <= reg_wdata[`IRQ_NUM_SRC-1:0];
                `IRQ_REG_PRIO: irq_priority_register <= reg_wdata[`IRQ_NUM_SRC-1:0];
                `IRQ_REG_CTRL: global_irq_enable <= reg_wdata[`IRQ_CTRL_GLOBAL_BIT];
                default: ;
            endcase
        end
    end

    assign sw_set = (reg_write && reg_addr == `IRQ_REG_PEND_SET) ?
        reg_wdata[`IRQ_NUM_SRC-1:0] : '0;
    assign sw_clr = (reg_write && reg_addr == `IRQ_REG_PEND_CLR) ?
        reg_wdata[`IRQ_NUM_SRC-1:0] : '0;

    ////////////////////////////////////////////////////////////////////
    // Pending flags; a set beats any clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < `IRQ_NUM_SRC; g++) begin : g_pend
            // RQ9 auto clear on vectoring
            assign hw_clr[g] = auto_clr_mask[g] && call_end && grant_idx == 4'(g);
            // RQ2 set regardless of enable
            assign next_pending[g] = src_event[g] || sw_set[g] ||
                (pending[g] && !sw_clr[g] && !hw_clr[g]);
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Call sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= irq_ctrl_pkg::ST_IDLE;
            call_cnt <= 3'h0;
            grant_idx <= 4'h0;
            grant_high <= 1'b0;
            call_req <= 1'b0;
            call_vector <= '0;
            call_start <= 1'b0;
        end else begin
            call_start <= 1'b0;
            case (state)
                irq_ctrl_pkg::ST_IDLE, irq_ctrl_pkg::ST_SERVICE: begin
                    // RQ3 RQ14 single grant with vector
                    if (take) begin
                        state <= irq_ctrl_pkg::ST_CALL;
                        call_cnt <= 3'h0;
                        grant_idx <= take_idx;
                        grant_high <= take_high;
                        call_req <= 1'b1;
                        call_vector <= `IRQ_VEC_BASE + 16'(take_idx) * `IRQ_VEC_STEP;
                    end else if (state == irq_ctrl_pkg::ST_SERVICE && return_from_interrupt_instruction_done) begin
                        // RQ4 RQ10 one instruction after return
                        state <= irq_ctrl_pkg::ST_RETURN;
                    end
                end
                irq_ctrl_pkg::ST_CALL: begin
                    // RQ13 four cycles to complete the call
                    call_cnt <= call_cnt + 3'h1;
                    if (call_cnt == `IRQ_CALL_LAST) begin
                        call_req <= 1'b0;
                        call_start <= 1'b1;
                        state <= irq_ctrl_pkg::ST_SERVICE;
                    end
                end
                irq_ctrl_pkg::ST_RETURN: begin
                    state <= irq_ctrl_pkg::ST_ONE_MORE;
                end
                irq_ctrl_pkg::ST_ONE_MORE: begin
                    if (instr_done) begin
                        state <= (active_low_lvl || active_high_lvl) ?
                            irq_ctrl_pkg::ST_SERVICE : irq_ctrl_pkg::ST_IDLE;
                        if (eligible != '0 && (take_high || hit_low && can_low)) begin
                            state <= irq_ctrl_pkg::ST_CALL;
                            call_cnt <= 3'h0;
                            grant_idx <= take_idx;
                            grant_high <= take_high;
                            call_req <= 1'b1;
                            call_vector <= `IRQ_VEC_BASE + 16'(take_idx) * `IRQ_VEC_STEP;
                        end
                    end
                end
                default: state <= irq_ctrl_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // RQ11 active level tracking, one nested low under high
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            active_low_lvl <= 1'b0;
            active_high_lvl <= 1'b0;
            low_saved <= 1'b0;
        end else if (call_end) begin
            // Level taken on entry to service, before any new decision
            if (grant_high) begin
                active_high_lvl <= 1'b1;
                low_saved <= active_low_lvl;
            end else begin
                active_low_lvl <= 1'b1;
            end
        end else if (state == irq_ctrl_pkg::ST_SERVICE && return_from_interrupt_instruction_done && !take) begin
            // RQ4 return frees the innermost level
            if (active_high_lvl) begin
                active_high_lvl <= 1'b0;
                active_low_lvl <= low_saved;
            end else begin
                active_low_lvl <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                `IRQ_REG_ENABLE: reg_rdata <= {1'b0, irq_enable_register};
                `IRQ_REG_PRIO: reg_rdata <= {1'b0, irq_priority_register};
                `IRQ_REG_PEND: reg_rdata <= {1'b0, pending};
                `IRQ_REG_CTRL: reg_rdata <= {15'h0000, global_irq_enable};
                `IRQ_REG_STATUS: reg_rdata <= {7'h00, grant_idx, call_req,
                    grant_high, active_high_lvl, active_low_lvl, 1'b0};
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_global_block;
        @(posedge clk_sys) disable iff (rst)
        (!global_irq_enable && state == irq_ctrl_pkg::ST_IDLE) |=> !call_req;
    endproperty
    a_global_block: assert property (p_global_block) else $error("request while globally off"); // RQ8

    sequence s_take;
        state == irq_ctrl_pkg::ST_IDLE && take;
    endsequence
    property p_call_len;
        @(posedge clk_sys) disable iff (rst)
        s_take |=> call_req [*4] ##1 !call_req;
    endproperty
    a_call_len: assert property (p_call_len) else $error("call length wrong"); // RQ13

    property p_start_pulse;
        @(posedge clk_sys) disable iff (rst)
        s_take |-> ##5 call_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("call start not at cycle five"); // RQ3

    property p_vec_stable;
        @(posedge clk_sys) disable iff (rst)
        (call_req && $past(call_req)) |-> $stable(call_vector);
    endproperty
    a_vec_stable: assert property (p_vec_stable) else $error("vector moved during grant"); // RQ14

    property p_event_sets;
        @(posedge clk_sys) disable iff (rst)
        src_event[0] |=> pending[0];
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("event lost"); // RQ2

    property p_no_high_preempt;
        @(posedge clk_sys) disable iff (rst)
        active_high_lvl && state == irq_ctrl_pkg::ST_SERVICE |-> !take;
    endproperty
    a_no_high_preempt: assert property (p_no_high_preempt) else $error("high preempted"); // RQ11

    property p_return_from_interrupt_instruction_gap;
        @(posedge clk_sys) disable iff (rst)
        (state == irq_ctrl_pkg::ST_SERVICE && return_from_interrupt_instruction_done && !take) |=>
            !call_req ##1 state == irq_ctrl_pkg::ST_ONE_MORE;
    endproperty
    a_return_from_interrupt_instruction_gap: assert property (p_return_from_interrupt_instruction_gap) else $error("no instruction after return"); // RQ10

    property p_disabled_ignored;
        @(posedge clk_sys) disable iff (rst)
        (state == irq_ctrl_pkg::ST_IDLE && (pending & irq_enable_register) == '0) |=> !call_req;
    endproperty
    a_disabled_ignored: assert property (p_disabled_ignored) else $error("disabled source taken"); // RQ5

    property p_one_more;
        @(posedge clk_sys) disable iff (rst)
        (state == irq_ctrl_pkg::ST_ONE_MORE && !instr_done) |=> !call_req;
    endproperty
    a_one_more: assert property (p_one_more) else $error("grant before further instruction"); // RQ10

    property p_auto_clear;
        @(posedge clk_sys) disable iff (rst)
        (call_end && auto_clr_mask[grant_idx] && !src_event[grant_idx] && !sw_set[grant_idx])
            |=> !pending[grant_idx];
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("auto-clear flag left set"); // RQ9
endmodule : irq_ctrl

/* irq_seq_model.sv */
// Behavioural model of the instruction sequencer facing the controller.
// Assumes one clock, synchronous active-high reset, call_start pulses from the controller.
`timescale 1ns/1ns

module irq_seq_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic call_req,
    input wire logic call_start,
    input wire logic [3:0] gap,
    input wire logic [3:0] svc_len,
    output logic instr_done,
    output logic return_from_interrupt_instruction_done
);
    logic [3:0] cnt;
    logic [3:0] left;
    logic [1:0] depth;
    logic [3:0] left_saved;
    logic extra;

    ////////////////////////////////////////////////////////////////
    // instructions, calls and returns
    always_ff @(posedge clk_sys) begin
        instr_done <= 1'b0;
        return_from_interrupt_instruction_done <= 1'b0;
        if (rst) begin
            cnt <= 4'h0;
            left <= 4'h0;
            left_saved <= 4'h0;
            depth <= 2'h0;
            extra <= 1'b0;
        end else if (call_start) begin
            depth <= depth + 2'h1;
            left <= svc_len;
            // Interrupted routine keeps its remaining length
            left_saved <= left;
            extra <= 1'b0;
            cnt <= 4'h0;
        end else if (call_req) begin
            // Core is busy with the long call
            cnt <= 4'h0;
        end else if (cnt < gap) begin
            cnt <= cnt + 4'h1;
        end else begin
            cnt <= 4'h0;
            if (depth != 2'h0 && left == 4'h0 && !extra) begin
                return_from_interrupt_instruction_done <= 1'b1;
                depth <= depth - 2'h1;
                left <= left_saved;
                // One further instruction follows every return
                extra <= 1'b1;
            end else begin
                instr_done <= 1'b1;
                extra <= 1'b0;
                if (depth != 2'h0 && !extra) begin
                    left <= left - 4'h1;
                end
            end
        end
    end
endmodule : irq_seq_model

/* two_level_interrupt_controller_tb.sv */
// Self-checking bench for the interrupt controller with a sequencer model.
// Assumes irq_ctrl_cfg.svh on the include path; clk_sys at 250 MHz.
`timescale 1ns/1ns
`include "irq_ctrl_cfg.svh"

module two_level_interrupt_controller_tb;
    logic clk_sys, rst, instr_done, return_from_interrupt_instruction_done, reg_write, reg_read;
    logic call_req, call_start;
    logic [14:0] src_event, pending;
    logic [3:0] reg_addr, gap, svc_len;
    logic [15:0] reg_wdata, reg_rdata, call_vector, cr_cnt;
    logic rd_flag;
    logic [15:0] rd_q[$];
    logic [15:0] vec_q[$];
    int n_fail, checks_done, j;

    irq_ctrl dut (.clk_sys(clk_sys), .rst(rst), .src_event(src_event),
        .instr_done(instr_done), .return_from_interrupt_instruction_done(return_from_interrupt_instruction_done), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .call_req(call_req), .call_vector(call_vector),
        .call_start(call_start), .pending(pending));
    irq_seq_model seq (.clk_sys(clk_sys), .rst(rst), .call_req(call_req),
        .call_start(call_start), .gap(gap), .svc_len(svc_len),
        .instr_done(instr_done), .return_from_interrupt_instruction_done(return_from_interrupt_instruction_done));

    ////////////////////////////////////////////////////////////////
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task results;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    function automatic logic [15:0] vec(input int i);
        return `IRQ_VEC_BASE + `IRQ_VEC_STEP * 16'(i);
    endfunction : vec

    task reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : reg_wr

    task reg_rd(input logic [3:0] a, input logic [15:0] exp);
        rd_q.push_back(exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
    endtask : reg_rd

    task fire(input logic [14:0] m);
        @(posedge clk_sys);
        src_event <= m;
        @(posedge clk_sys);
        src_event <= 15'h0000;
    endtask : fire

    task wait_call(input int left);
        int k;
        for (k = 0; k < 300 && vec_q.size() != left; k++) @(posedge clk_sys);
        if (vec_q.size() != left) check("call_wait", 16'h0000, 16'h0001);
    endtask : wait_call

    task wait_return_from_interrupt_instruction;
        int k;
        for (k = 0; k < 300 && return_from_interrupt_instruction_done !== 1'b1; k++) @(posedge clk_sys);
        if (return_from_interrupt_instruction_done !== 1'b1) check("return_from_interrupt_instruction_wait", 16'h0000, 16'h0001);
        @(posedge clk_sys);
    endtask : wait_return_from_interrupt_instruction

    ////////////////////////////////////////////////////////////////
    // Result watcher
    always @(negedge clk_sys) begin
        if (rd_flag) check("reg_rdata", reg_rdata, rd_q.pop_front());
        rd_flag = reg_read;
        if (rst) cr_cnt = 16'h0000;
        else if (call_req) cr_cnt++;
        if (call_start) begin
            check("call_req_cycles", cr_cnt, 16'(`IRQ_CALL_CYCLES));
            cr_cnt = 16'h0000;
            if (vec_q.size() == 0) check("unexpected_call", 16'h0001, 16'h0000);
            else check("call_vector", call_vector, vec_q.pop_front());
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        n_fail++;
        results();
    end

    initial begin
        rst = 1'b1;
        {src_event, reg_addr, reg_wdata, reg_write, reg_read} = '0;
        gap = 4'h1;
        svc_len = 4'h8;
        rd_flag = 1'b0;
        cr_cnt = 16'h0000;
        n_fail = 0;
        checks_done = 0;
        void'($urandom(32'hb23f));
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        for (int a = 0; a < 5; a++) reg_rd(4'(a), 16'h0000);
        reg_rd(4'hf, 16'h0000);
        // flag set with global enable off
        j = $urandom_range(14, 0);
        reg_wr(`IRQ_REG_ENABLE, 16'h7fff);
        fire(15'(1 << j));
        reg_rd(`IRQ_REG_PEND, 16'(1 << j));
        check("pending", {1'b0, pending}, 16'(1 << j));
        repeat (30) @(posedge clk_sys);
        reg_wr(`IRQ_REG_PEND_CLR, 16'h7fff);
        reg_wr(`IRQ_REG_ENABLE, 16'h7fff & ~16'(1 << j));
        reg_wr(`IRQ_REG_CTRL, 16'h0001);
        fire(15'(1 << j));
        repeat (30) @(posedge clk_sys);
        reg_wr(`IRQ_REG_PEND_CLR, 16'h7fff);
        // every source vectors, auto-clear for orders 0..3
        for (int i = 0; i < 15; i++) begin
            // Core needs a cycle after a return
            gap <= 4'($urandom_range(3, 1));
            reg_wr(`IRQ_REG_ENABLE, 16'(1 << i));
            vec_q.push_back(vec(i));
            fire(15'(1 << i));
            wait_call(0);
            reg_rd(`IRQ_REG_PEND, (i < 4) ? 16'h0000 : 16'(1 << i));
            reg_wr(`IRQ_REG_PEND_CLR, 16'h7fff);
            wait_return_from_interrupt_instruction();
        end
        reg_wr(`IRQ_REG_ENABLE, 16'h0020);
        vec_q.push_back(vec(5));
        vec_q.push_back(vec(5));
        fire(15'h0020);
        wait_call(1);
        wait_return_from_interrupt_instruction();
        wait_call(0);
        reg_wr(`IRQ_REG_PEND_CLR, 16'h0020);
        wait_return_from_interrupt_instruction();
        reg_wr(`IRQ_REG_ENABLE, 16'h7fff);
        reg_wr(`IRQ_REG_PRIO, 16'h0e00);
        reg_rd(`IRQ_REG_PRIO, 16'h0e00);
        vec_q.push_back(vec(9));
        vec_q.push_back(vec(2));
        vec_q.push_back(vec(6));
        fire(15'h0244);
        for (int n = 2; n >= 0; n--) begin
            wait_call(n);
            reg_wr(`IRQ_REG_PEND_CLR, (n == 2) ? 16'h0200 : (n == 1) ? 16'h0004 : 16'h0040);
            wait_return_from_interrupt_instruction();
        end
        // high preempts low, high not preempted
        vec_q.push_back(vec(7));
        fire(15'h0080);
        wait_call(0);
        reg_wr(`IRQ_REG_PEND_CLR, 16'h0080);
        vec_q.push_back(vec(10));
        fire(15'h0400);
        wait_call(0);
        fire(15'h0800);
        reg_wr(`IRQ_REG_PEND_CLR, 16'h0400);
        wait_return_from_interrupt_instruction();
        vec_q.push_back(vec(11));
        wait_call(0);
        reg_wr(`IRQ_REG_PEND_CLR, 16'h0800);
        wait_return_from_interrupt_instruction();
        wait_return_from_interrupt_instruction();
        repeat (20) @(posedge clk_sys);
        // global enable written to zero blocks enabled sources
        reg_wr(`IRQ_REG_CTRL, 16'h0000);
        reg_wr(`IRQ_REG_PEND_SET, 16'h0011);
        reg_rd(`IRQ_REG_PEND, 16'h0011);
        repeat (30) @(posedge clk_sys);
        // Second reset mid-run
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        reg_rd(`IRQ_REG_ENABLE, 16'h0000);
        reg_rd(`IRQ_REG_PRIO, 16'h0000);
        check("pending_rst", {1'b0, pending}, 16'h0000);
        check("vector_rst", call_vector, 16'h0000);
        repeat (4) @(posedge clk_sys);
        results();
    end
endmodule : two_level_interrupt_controller_tb
